// >>> rtl/ibsf_top.v
// Bus-busy and addressed-as-slave status logic with its register slave.
//
// Summary of operation
// - START sets the bus-busy flag; STOP clears it.
// - With module held in reset, no START/STOP seen; bus-busy keeps its value.
// - After power-up bus-busy reads zero until software releases the module reset.
// - After release bus-busy changes only at the next START or STOP.
// - Own address match sets addressed-as-slave in seven- and ten-bit modes.
// - Seven-bit: NACK, STOP or repeated START clear it; other address does not.
// - Ten-bit: NACK, STOP or other address clear it; repeated START does not.
// - Once addressed-as-slave clears, the slave stops acknowledging and transferring.
`timescale 1ns/1ns
`include "ibsf_defs.vh"
module ibsf_top (
   // Clock and reset.
   input  wire        CLK_IN,
   input  wire        RST_IN,
   // Avalon-MM register slave.
   input  wire [4:0]  AVS_ADDRESS_IN,
   input  wire        AVS_READ_IN,
   input  wire        AVS_WRITE_IN,
   input  wire [3:0]  AVS_BYTEENABLE_IN,
   input  wire [31:0] AVS_WRITEDATA_IN,
   output reg  [31:0] AVS_READDATA_OUT,
   output reg         AVS_WAITREQUEST_OUT,
   // Interrupt.
   output wire        IRQ_OUT,
   // Serial bus pins; SDA is open drain.
   input  wire        SCL_IN,
   input  wire        SDA_IN,
   output reg         SDA_OUT,
   output reg         SDA_OE_N_OUT
);
   localparam ST_IDLE  = 2'd0;
   localparam ST_ADDR1 = 2'd1;
   localparam ST_ADDR2 = 2'd2;
   localparam ST_DATA  = 2'd3;

   // Registers.
   reg  [1:0]                 ctrl;
   reg  [9:0]                 own_addr;
   reg  [`IBSF_INT_WIDTH-1:0] int_mask;
   reg                        bus_busy_flag;
   reg                        addressed_as_slave_flag;

   // Line sampling.
   wire [1:0]                 line_sync;
   wire                       scl_s;
   wire                       sda_s;
   reg                        scl_q;
   reg                        sda_q;

   // Slave byte engine.
   reg  [1:0]                 state;
   reg  [3:0]                 bit_cnt;
   reg  [6:0]                 shift;
   reg                        rw;
   reg                        ack_pending;
   reg                        match_pulse;
   reg                        nomatch_pulse;
   reg                        nack_pulse;

   // Bus access and interrupt wiring.
   wire                       module_out_of_reset;
   wire                       ten_bit;
   wire                       access;
   wire                       wr_en;
   wire [`IBSF_INT_WIDTH-1:0] int_status;
   wire [`IBSF_INT_WIDTH-1:0] int_event;
   wire [`IBSF_INT_WIDTH-1:0] int_clear;
   wire                       start_det;
   wire                       stop_det;
   wire                       scl_rise;
   wire                       scl_fall;
   wire [7:0]                 byte_in;
   wire                       slave_clear;
   wire                       repeated_start;
   reg  [31:0]                next_readdata;

   assign module_out_of_reset = ctrl[`IBSF_CTRL_OUT_OF_RESET];
   assign ten_bit             = ctrl[`IBSF_CTRL_TEN_BIT];

   ibsf_sync #(
      .W (2)
   ) u_sync (
      .clk_in   (CLK_IN),
      .rst_in   (RST_IN),
      .async_in ({SCL_IN, SDA_IN}),
      .sync_out (line_sync)
   );

   assign scl_s = line_sync[1];
   assign sda_s = line_sync[0];

   // The previous sample runs even while the module is held in reset, so a
   // release never manufactures an edge from a stale sample.
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   // Conditions are gated off entirely while the module is held in reset.
   assign start_det = module_out_of_reset & scl_s & scl_q & sda_q & ~sda_s;
   assign stop_det  = module_out_of_reset & scl_s & scl_q & ~sda_q & sda_s;
   assign scl_rise  = module_out_of_reset & scl_s & ~scl_q;
   assign scl_fall  = module_out_of_reset & ~scl_s & scl_q;
   assign byte_in   = {shift, sda_s};
   assign repeated_start = start_det & bus_busy_flag;

   // Bus-busy tracks conditions only; it is never reloaded from the line
   // levels, so it holds its old value across a module reset.
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         bus_busy_flag <= 1'b0;
      end else if (start_det) begin
         bus_busy_flag <= 1'b1;
      end else if (stop_det) begin
         bus_busy_flag <= 1'b0;
      end
   end

   // Clearing events depend on the addressing mode.
   assign slave_clear = nack_pulse | stop_det |
                        (ten_bit ? nomatch_pulse : repeated_start);

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         addressed_as_slave_flag <= 1'b0;
      end else if (!module_out_of_reset) begin
         addressed_as_slave_flag <= 1'b0;
      end else if (match_pulse) begin
         addressed_as_slave_flag <= 1'b1;
      end else if (slave_clear) begin
         addressed_as_slave_flag <= 1'b0;
      end
   end

   // Byte engine: bits are taken on SCL rising edges, the acknowledge is
   // driven from the falling edge after the eighth bit to the next fall.
   always @(posedge CLK_IN) begin
      if (RST_IN || !module_out_of_reset) begin
         state         <= ST_IDLE;
         bit_cnt       <= 4'h0;
         shift         <= 7'h00;
         rw            <= 1'b0;
         ack_pending   <= 1'b0;
         match_pulse   <= 1'b0;
         nomatch_pulse <= 1'b0;
         nack_pulse    <= 1'b0;
         SDA_OUT       <= 1'b0;
         SDA_OE_N_OUT  <= 1'b1;
      end else begin
         match_pulse   <= 1'b0;
         nomatch_pulse <= 1'b0;
         nack_pulse    <= 1'b0;
         SDA_OUT       <= 1'b0;
         if (start_det) begin
            state        <= ST_ADDR1;
            bit_cnt      <= 4'h0;
            ack_pending  <= 1'b0;
            SDA_OE_N_OUT <= 1'b1;
         end else if (stop_det) begin
            state        <= ST_IDLE;
            ack_pending  <= 1'b0;
            SDA_OE_N_OUT <= 1'b1;
         end else if (slave_clear && state == ST_DATA) begin
            state        <= ST_IDLE;
            ack_pending  <= 1'b0;
            SDA_OE_N_OUT <= 1'b1;
         end else if (scl_fall) begin
            SDA_OE_N_OUT <= ~(ack_pending && bit_cnt == 4'h8);
         end else if (scl_rise && state != ST_IDLE) begin
            if (bit_cnt == 4'h8) begin
               bit_cnt     <= 4'h0;
               ack_pending <= 1'b0;
               // In a read the ninth bit is the master's acknowledge.
               if (state == ST_DATA && rw && sda_s) begin
                  nack_pulse <= 1'b1;
                  state      <= ST_IDLE;
               end
            end else if (bit_cnt == 4'h7) begin
               bit_cnt <= 4'h8;
               case (state)
                  ST_ADDR1: begin
                     if (!ten_bit) begin
                        if (byte_in[7:1] == own_addr[6:0]) begin
                           match_pulse <= 1'b1;
                           rw          <= byte_in[0];
                           ack_pending <= 1'b1;
                           state       <= ST_DATA;
                        end else begin
                           nomatch_pulse <= 1'b1;
                           state         <= ST_IDLE;
                        end
                     end else if (byte_in[7:3] == `IBSF_TEN_BIT_HEADER &&
                                  byte_in[2:1] == own_addr[9:8] && !byte_in[0]) begin
                        ack_pending <= 1'b1;
                        state       <= ST_ADDR2;
                     end else if (byte_in[7:3] == `IBSF_TEN_BIT_HEADER &&
                                  byte_in[2:1] == own_addr[9:8] &&
                                  addressed_as_slave_flag) begin
                        // Read header after a repeated START keeps the match.
                        match_pulse <= 1'b1;
                        rw          <= 1'b1;
                        ack_pending <= 1'b1;
                        state       <= ST_DATA;
                     end else begin
                        nomatch_pulse <= 1'b1;
                        state         <= ST_IDLE;
                     end
                  end
                  ST_ADDR2: begin
                     if (byte_in == own_addr[7:0]) begin
                        match_pulse <= 1'b1;
                        rw          <= 1'b0;
                        ack_pending <= 1'b1;
                        state       <= ST_DATA;
                     end else begin
                        nomatch_pulse <= 1'b1;
                        state         <= ST_IDLE;
                     end
                  end
                  ST_DATA: begin
                     // Received bytes are acknowledged only while addressed.
                     ack_pending <= ~rw & addressed_as_slave_flag;
                  end
                  default: begin
                     state <= ST_IDLE;
                  end
               endcase
            end else begin
               bit_cnt <= bit_cnt + 4'h1;
               shift   <= byte_in[6:0];
            end
         end
      end
   end

   // Avalon-MM slave: one wait cycle, then the access completes.
   assign access = (AVS_READ_IN | AVS_WRITE_IN) & ~AVS_WAITREQUEST_OUT;
   assign wr_en  = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT;

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         AVS_WAITREQUEST_OUT <= 1'b1;
      end else if ((AVS_READ_IN | AVS_WRITE_IN) && AVS_WAITREQUEST_OUT) begin
         AVS_WAITREQUEST_OUT <= 1'b0;
      end else begin
         AVS_WAITREQUEST_OUT <= 1'b1;
      end
   end

   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         ctrl     <= `IBSF_CTRL_RESET;
         own_addr <= `IBSF_OWN_ADDR_RESET;
         int_mask <= `IBSF_INT_MASK_RESET;
      end else if (wr_en) begin
         case (AVS_ADDRESS_IN)
            `IBSF_OFS_CTRL: begin
               if (AVS_BYTEENABLE_IN[0]) begin
                  ctrl <= AVS_WRITEDATA_IN[1:0];
               end
            end
            `IBSF_OFS_OWN_ADDR: begin
               if (AVS_BYTEENABLE_IN[0]) begin
                  own_addr[7:0] <= AVS_WRITEDATA_IN[7:0];
               end
               if (AVS_BYTEENABLE_IN[1]) begin
                  own_addr[9:8] <= AVS_WRITEDATA_IN[9:8];
               end
            end
            `IBSF_OFS_INT_MASK: begin
               if (AVS_BYTEENABLE_IN[0]) begin
                  int_mask <= AVS_WRITEDATA_IN[`IBSF_INT_WIDTH-1:0];
               end
            end
            default: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   always @* begin
      next_readdata = 32'h0000_0000;
      case (AVS_ADDRESS_IN)
         `IBSF_OFS_CTRL:       next_readdata[1:0] = ctrl;
         `IBSF_OFS_OWN_ADDR:   next_readdata[9:0] = own_addr;
         `IBSF_OFS_STATUS:     next_readdata[1:0] = {addressed_as_slave_flag, bus_busy_flag};
         `IBSF_OFS_INT_STATUS: next_readdata[`IBSF_INT_WIDTH-1:0] = int_status;
         `IBSF_OFS_INT_MASK:   next_readdata[`IBSF_INT_WIDTH-1:0] = int_mask;
         default:              next_readdata = 32'h0000_0000;
      endcase
   end

   // Read data are loaded in the wait cycle and stand while waitrequest is low.
   always @(posedge CLK_IN) begin
      if (RST_IN) begin
         AVS_READDATA_OUT <= 32'h0000_0000;
      end else if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
         AVS_READDATA_OUT <= next_readdata;
      end
   end

   assign int_event = {slave_clear & addressed_as_slave_flag & ~match_pulse,
                       match_pulse, stop_det, start_det};
   assign int_clear = (wr_en && access && AVS_ADDRESS_IN == `IBSF_OFS_INT_STATUS &&
                       AVS_BYTEENABLE_IN[0]) ?
                      AVS_WRITEDATA_IN[`IBSF_INT_WIDTH-1:0] : {`IBSF_INT_WIDTH{1'b0}};

   ibsf_irq u_irq (
      .clk_in     (CLK_IN),
      .rst_in     (RST_IN),
      .event_in   (int_event),
      .clear_in   (int_clear),
      .mask_in    (int_mask),
      .status_out (int_status),
      .irq_out    (IRQ_OUT)
   );
endmodule // ibsf_top

// >>> common/ibsf_defs.vh
// Register map, field positions and reset values of the bus-busy and slave-match block.
`ifndef IBSF_DEFS_VH
`define IBSF_DEFS_VH

// Byte offsets on the register bus.
`define IBSF_OFS_CTRL       5'h00
`define IBSF_OFS_OWN_ADDR   5'h04
`define IBSF_OFS_STATUS     5'h08
`define IBSF_OFS_INT_STATUS 5'h0c
`define IBSF_OFS_INT_MASK   5'h10

// Control register fields.
`define IBSF_CTRL_OUT_OF_RESET 0
`define IBSF_CTRL_TEN_BIT      1

// Status register fields.
`define IBSF_STAT_BUS_BUSY  0
`define IBSF_STAT_ADDRESSED 1

// Interrupt status and mask fields.
`define IBSF_INT_START      0
`define IBSF_INT_STOP       1
`define IBSF_INT_ADDRESSED  2
`define IBSF_INT_RELEASED   3
`define IBSF_INT_WIDTH      4

// Reset values.
`define IBSF_CTRL_RESET     2'h0
`define IBSF_OWN_ADDR_RESET 10'h000
`define IBSF_INT_MASK_RESET 4'h0

// Fixed high part of a ten-bit address header byte.
`define IBSF_TEN_BIT_HEADER 5'h1e

`endif

// >>> rtl/ibsf_sync.v
// Two-stage synchroniser for a group of asynchronous inputs.
`timescale 1ns/1ns
module ibsf_sync #(
   parameter W = 2
) (
   // Clock and reset.
   input  wire         clk_in,
   input  wire         rst_in,
   // Asynchronous levels and their synchronised copies.
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         // Idle bus lines are high, so both stages reset high.
         always @(posedge clk_in) begin
            if (rst_in) begin
               stage1[i] <= 1'b1;
               stage2[i] <= 1'b1;
            end else begin
               stage1[i] <= async_in[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate

   assign sync_out = stage2;
endmodule // ibsf_sync

// >>> rtl/ibsf_irq.v
// Sticky event status with write-one-to-clear, mask and a level interrupt.
`timescale 1ns/1ns
`include "ibsf_defs.vh"
module ibsf_irq (
   // Clock and reset.
   input  wire                       clk_in,
   input  wire                       rst_in,
   // Event pulses and software clear strobes.
   input  wire [`IBSF_INT_WIDTH-1:0] event_in,
   input  wire [`IBSF_INT_WIDTH-1:0] clear_in,
   input  wire [`IBSF_INT_WIDTH-1:0] mask_in,
   // Status and interrupt.
   output reg  [`IBSF_INT_WIDTH-1:0] status_out,
   output reg                        irq_out
);
   genvar i;
   generate
      for (i = 0; i < `IBSF_INT_WIDTH; i = i + 1) begin : g_flag
         // A new event in the clearing cycle keeps the bit set.
         always @(posedge clk_in) begin
            if (rst_in) begin
               status_out[i] <= 1'b0;
            end else if (event_in[i]) begin
               status_out[i] <= 1'b1;
            end else if (clear_in[i]) begin
               status_out[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always @(posedge clk_in) begin
      if (rst_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(status_out & mask_in);
      end
   end
endmodule // ibsf_irq

// >>> testbench/ibsf_checker.sv
// Port-level assertions for the bus-busy and slave-match status block.
`timescale 1ns/1ns
`include "ibsf_defs.vh"
module ibsf_checker (
   // Clock and reset.
   input wire        CLK_IN,
   input wire        RST_IN,
   // Register bus.
   input wire [4:0]  AVS_ADDRESS_IN,
   input wire        AVS_READ_IN,
   input wire        AVS_WRITE_IN,
   input wire [3:0]  AVS_BYTEENABLE_IN,
   input wire [31:0] AVS_WRITEDATA_IN,
   input wire [31:0] AVS_READDATA_OUT,
   input wire        AVS_WAITREQUEST_OUT,
   // Interrupt and serial pins.
   input wire        IRQ_OUT,
   input wire        SCL_IN,
   input wire        SDA_OUT,
   input wire        SDA_OE_N_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);
   wire wr_done = AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_BYTEENABLE_IN[0];
   wire rd_done = AVS_READ_IN && !AVS_WAITREQUEST_OUT;
   chk_reset_quiet:
   assert property (disable iff (1'b0) RST_IN |=>
      AVS_WAITREQUEST_OUT && SDA_OE_N_OUT && !IRQ_OUT) else $error("outputs busy after reset");
   chk_one_wait:
   assert property ($rose(AVS_READ_IN || AVS_WRITE_IN) |=> !AVS_WAITREQUEST_OUT)
      else $error("request not answered after one wait");
   chk_wait_pulse:
   assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT) else $error("wait low too long");
   chk_unmapped_zero:
   assert property (rd_done && AVS_ADDRESS_IN > 5'h10 |-> AVS_READDATA_OUT == 32'h0)
      else $error("unmapped read not zero");
   chk_status_upper:
   assert property (rd_done && AVS_ADDRESS_IN == `IBSF_OFS_STATUS |-> AVS_READDATA_OUT[31:2] == 0)
      else $error("status spare bits set");
   chk_open_drain:
   assert property (!SDA_OUT) else $error("data line driven high");
   chk_ack_scl_low:
   assert property ($changed(SDA_OE_N_OUT) |-> !SCL_IN) else $error("data drive moved with clock high");
   chk_ack_span:
   assert property ($fell(SDA_OE_N_OUT) |-> !SDA_OE_N_OUT [*8] ##[1:16] SDA_OE_N_OUT)
      else $error("ack drive length wrong");
   chk_mask_off:
   assert property (wr_done && AVS_ADDRESS_IN == `IBSF_OFS_INT_MASK &&
      AVS_WRITEDATA_IN[3:0] == 4'h0 |=> ##1 !IRQ_OUT) else $error("masked interrupt high");
   chk_hold_release:
   assert property (wr_done && AVS_ADDRESS_IN == `IBSF_OFS_CTRL && !AVS_WRITEDATA_IN[0]
      |=> ##1 SDA_OE_N_OUT [*4]) else $error("data driven in module reset");
endmodule // ibsf_checker

// >>> testbench/ibsf_i2c_master.sv
// Behavioural bus master on the far side of the serial pins.
`timescale 1ns/1ns
module ibsf_i2c_master (
   // Bus level and drives; a drive of 1 releases the line.
   input  wire sda_in,
   output reg  scl_out,
   output reg  sda_out
);
   // The clock stands still between calls, so software may poll mid-frame.
   initial begin
      scl_out = 1'b1;
      sda_out = 1'b1;
   end
   // Pins change by non-blocking assignment, as calls begin on clock edges.
   task start;
      begin
         sda_out <= 1'b1;
         #40 scl_out <= 1'b1;
         #40 sda_out <= 1'b0;
         #40 scl_out <= 1'b0;
      end
   endtask
   task stop;
      begin
         sda_out <= 1'b0;
         #40 scl_out <= 1'b1;
         #40 sda_out <= 1'b1;
         #80;
      end
   endtask
   task bit_io(input logic b, output logic r);
      begin
         sda_out <= b;
         #40 scl_out <= 1'b1;
         #40 r = sda_in;
         #40 scl_out <= 1'b0;
         #40;
      end
   endtask
   // Eight bits most significant first, then the acknowledge bit.
   task xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
             output logic ack_out);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(tx[i], rx[i]);
         end
         bit_io(ack_in, ack_out);
      end
   endtask
endmodule // ibsf_i2c_master

// >>> testbench/ibsf_top_test.sv
// Self-checking bench for the bus-busy and slave-match status block.
`timescale 1ns/1ns
`include "ibsf_defs.vh"
module ibsf_top_test;
   logic        CLK_IN = 1'b0;
   logic        RST_IN = 1'b1;
   logic [4:0]  AVS_ADDRESS_IN = 5'h00;
   logic        AVS_READ_IN = 1'b0;
   logic        AVS_WRITE_IN = 1'b0;
   logic [31:0] AVS_WRITEDATA_IN = 32'h0;
   wire  [31:0] AVS_READDATA_OUT;
   wire         AVS_WAITREQUEST_OUT;
   wire         IRQ_OUT;
   wire         SDA_OUT;
   wire         SDA_OE_N_OUT;
   wire         scl;
   wire         sda_m;
   wire         sda = sda_m & (SDA_OE_N_OUT | SDA_OUT);
   logic [31:0] q;
   logic [7:0]  rx;
   logic        ack;
   integer      miscompares = 0;
   integer      cmp_count = 0;
   ibsf_top DUT (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
      .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_BYTEENABLE_IN(4'hf),
      .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
      .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .IRQ_OUT(IRQ_OUT), .SCL_IN(scl),
      .SDA_IN(sda), .SDA_OUT(SDA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT));
   ibsf_i2c_master m (.sda_in(sda), .scl_out(scl), .sda_out(sda_m));
   initial begin
      forever #5 CLK_IN = ~CLK_IN;
   end
   task complete_run;
      begin
         $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
         end
      end
   endtask
   // Waitrequest is sampled at rising edges; the edge that sees it low completes the access.
   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      integer n;
      begin
         @(posedge CLK_IN);
         AVS_ADDRESS_IN <= a;
         AVS_WRITEDATA_IN <= d;
         AVS_READ_IN <= !wr;
         AVS_WRITE_IN <= wr;
         n = 0;
         @(posedge CLK_IN);
         while (AVS_WAITREQUEST_OUT !== 1'b0) begin
            n = n + 1;
            if (n == 50) begin
               miscompares = miscompares + 1;
               complete_run;
            end
            @(posedge CLK_IN);
         end
         q = AVS_READDATA_OUT;
         AVS_READ_IN <= 1'b0;
         AVS_WRITE_IN <= 1'b0;
      end
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task rd_chk(input logic [4:0] a, input logic [31:0] e);
      begin
         bus(1'b0, a, 32'h0);
         check($sformatf("register %h", a), q, e);
      end
   endtask
   task st(input logic [31:0] e);
      rd_chk(`IBSF_OFS_STATUS, e);
   endtask
   task irq(input logic e);
      begin
         repeat (2) @(negedge CLK_IN);
         check("interrupt", IRQ_OUT, e);
      end
   endtask
   task xa(input logic [7:0] b, input logic e);
      begin
         m.xfer(b, 1'b1, rx, ack);
         check("ack bit", ack, e);
      end
   endtask
   task t_reset;
      begin
         rd_chk(`IBSF_OFS_CTRL, 32'h0);
         rd_chk(`IBSF_OFS_INT_MASK, 32'h0);
         rd_chk(5'h14, 32'h0);
         m.start;
         st(32'h0);
      end
   endtask
   task t_busy;
      begin
         wr(`IBSF_OFS_CTRL, 32'h1);
         st(32'h0);
         m.stop;
         st(32'h0);
         wr(`IBSF_OFS_INT_STATUS, 32'hf);
         wr(`IBSF_OFS_INT_MASK, 32'h1);
         irq(1'b0);
         m.start;
         st(32'h1);
         irq(1'b1);
         wr(`IBSF_OFS_INT_MASK, 32'h0);
         irq(1'b0);
         wr(`IBSF_OFS_INT_MASK, 32'h1);
         irq(1'b1);
         wr(`IBSF_OFS_INT_STATUS, 32'h1);
         irq(1'b0);
         wr(`IBSF_OFS_CTRL, 32'h0);
         m.stop;
         st(32'h1);
         wr(`IBSF_OFS_CTRL, 32'h1);
         st(32'h1);
         m.start;
         m.stop;
         st(32'h0);
      end
   endtask
   task t_seven;
      begin
         wr(`IBSF_OFS_OWN_ADDR, 32'h2a);
         m.start;
         xa(8'h54, 1'b0);
         st(32'h3);
         rd_chk(`IBSF_OFS_INT_STATUS, 32'h7);
         wr(`IBSF_OFS_INT_STATUS, 32'hf);
         xa(8'h55, 1'b0);
         m.start;
         st(32'h1);
         rd_chk(`IBSF_OFS_INT_STATUS, 32'h9);
         xa(8'h30, 1'b1);
         m.start;
         xa(8'h55, 1'b0);
         m.xfer(8'hff, 1'b1, rx, ack);
         check("slave byte", rx, 8'hff);
         st(32'h1);
         m.start;
         xa(8'h54, 1'b0);
         m.stop;
         st(32'h0);
      end
   endtask
   task t_ten;
      begin
         wr(`IBSF_OFS_CTRL, 32'h3);
         wr(`IBSF_OFS_OWN_ADDR, 32'h2a5);
         m.start;
         xa(8'hf4, 1'b0);
         xa(8'ha5, 1'b0);
         st(32'h3);
         m.start;
         st(32'h3);
         xa(8'hf5, 1'b0);
         m.xfer(8'hff, 1'b1, rx, ack);
         st(32'h1);
         m.start;
         xa(8'hf4, 1'b0);
         xa(8'ha5, 1'b0);
         m.start;
         m.xfer(8'hf4, 1'b1, rx, ack);
         xa(8'h11, 1'b1);
         st(32'h1);
         m.start;
         xa(8'hf4, 1'b0);
         xa(8'ha5, 1'b0);
         m.stop;
         st(32'h0);
      end
   endtask
   initial begin
      #900000;
      miscompares = miscompares + 1;
      complete_run;
   end
   initial begin
      repeat (16) @(posedge CLK_IN);
      RST_IN <= 1'b0;
      t_reset;
      t_busy;
      t_seven;
      t_ten;
      complete_run;
   end
endmodule // ibsf_top_test
bind ibsf_top ibsf_checker chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN),
   .AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
   .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
   .IRQ_OUT(IRQ_OUT), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT));
